// *** ack_latch_ctrl.sv ***
`timescale 1ns/10ps
module ack_latch_ctrl
  import ack_latch_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // avalon-mm slave
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  // serial bus pins
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // latch clear pulses
  output logic             serial_channel_zero_clear,
  output logic             serial_channel_one_clear,
  // interrupt
  output logic             irq
);

  logic                scl_s;
  logic                sda_s;
  logic                scl_prev_q;
  logic                sda_prev_q;
  logic                scl_rise;
  logic                scl_fall;
  logic                start_seen;
  logic                stop_seen;
  logic                resp_q;
  logic                wr_go;
  logic                rd_first;
  logic                lane0;
  logic                ack_value_bit_q;
  logic                bus_ack_q;
  logic                ack_check_enable_q;
  logic                transmit_select_q;
  logic [3:0]          bit_cnt_q;
  logic                in_frame_q;
  logic                ack_window_q;
  logic                ack_sample;
  logic                sda_oe_q;
  logic [IRQ_BITS-1:0] irq_stat_q;
  logic [IRQ_BITS-1:0] irq_mask_q;
  logic [IRQ_BITS-1:0] irq_set;
  logic [IRQ_BITS-1:0] irq_clr;
  logic [31:0]         rd_mux;
  logic [31:0]         readdata_q;
  logic [3:0]          code_wr;
  logic                dec_ch0;
  logic                dec_ch1;
  logic                dec_bad;
  logic                code_wr_go;
  logic                clr_ch0_q;
  logic                clr_ch1_q;
  logic                ack_check_clear;

  // pin synchronisers
  pin_sync u_scl_sync (
    .sys_clk    (sys_clk),
    .srst       (srst),
    .pin_in     (scl_in),
    .pin_sync_q (scl_s)
  );

  pin_sync u_sda_sync (
    .sys_clk    (sys_clk),
    .srst       (srst),
    .pin_in     (sda_in),
    .pin_sync_q (sda_s)
  );

  // edge detection on synchronised levels
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end
    else
    begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  assign scl_rise   = scl_s & ~scl_prev_q;
  assign scl_fall   = ~scl_s & scl_prev_q;
  assign start_seen = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  assign stop_seen  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

  // bus slave handshake: one wait cycle per access
  assign waitrequest = (read | write) & ~resp_q;
  assign wr_go       = write & resp_q;
  assign rd_first    = read & ~resp_q;
  assign lane0       = byteenable[0];

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      resp_q <= 1'b0;
    else
      resp_q <= (read | write) & ~resp_q;
  end

  // software writes to the control register
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      ack_check_enable_q <= ACK_CHECK_RST;
      transmit_select_q  <= TX_SELECT_RST;
    end
    else if (wr_go && lane0 && address == CTRL_OFS)
    begin
      ack_check_enable_q <= writedata[ACK_CHECK_POS];
      transmit_select_q  <= writedata[TX_SELECT_POS];
    end
  end

  assign ack_check_clear = wr_go && lane0 && address == CTRL_OFS && !writedata[ACK_CHECK_POS];

  // stored acknowledge for reception
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      ack_value_bit_q <= ACK_VALUE_RST;
    else if (wr_go && lane0 && address == STATUS_OFS)
      ack_value_bit_q <= writedata[ACK_VALUE_POS];
  end

  // acknowledge clock of a transmitted byte
  assign ack_sample = scl_rise && in_frame_q && bit_cnt_q == ACK_CLOCK_IDX
                      && transmit_select_q && ack_check_enable_q;

  // bus-sampled acknowledge; a sample wins over a clear
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      bus_ack_q <= 1'b0;
    else if (ack_sample)
      bus_ack_q <= sda_s;
    else if (ack_check_clear || clr_ch0_q)
      bus_ack_q <= 1'b0;
  end

  // bit counter and frame tracking
  always_ff @(posedge sys_clk)
  begin
    if (srst || clr_ch0_q)
    begin
      bit_cnt_q  <= 4'h0;
      in_frame_q <= 1'b0;
    end
    else if (start_seen)
    begin
      bit_cnt_q  <= 4'h0;
      in_frame_q <= 1'b1;
    end
    else if (stop_seen)
    begin
      bit_cnt_q  <= 4'h0;
      in_frame_q <= 1'b0;
    end
    else if (scl_rise && in_frame_q)
    begin
      if (bit_cnt_q == ACK_CLOCK_IDX)
        bit_cnt_q <= 4'h0;
      else
        bit_cnt_q <= bit_cnt_q + 4'h1;
    end
  end

  // ninth clock window, opened at the falling edge after the eighth bit
  always_ff @(posedge sys_clk)
  begin
    if (srst || clr_ch0_q || start_seen || stop_seen)
      ack_window_q <= 1'b0;
    else if (scl_fall && in_frame_q)
      ack_window_q <= bit_cnt_q == ACK_CLOCK_IDX;
  end

  // open-drain acknowledge drive in receive mode
  always_ff @(posedge sys_clk)
  begin
    if (srst || clr_ch0_q)
      sda_oe_q <= 1'b0;
    else if (start_seen || stop_seen)
      sda_oe_q <= 1'b0;
    else if (scl_fall && in_frame_q)
      sda_oe_q <= bit_cnt_q == ACK_CLOCK_IDX && !transmit_select_q && !ack_value_bit_q;
  end

  assign sda_oe  = sda_oe_q;
  assign sda_out = 1'b0;

  // clear-code write: reserved bits ignored, code not stored
  assign code_wr    = writedata[3:0];
  assign code_wr_go = wr_go && lane0 && address == SWITCH_OFS;

  clear_code_decode u_decode (
    .code      (code_wr),
    .clear_ch0 (dec_ch0),
    .clear_ch1 (dec_ch1),
    .bad_code  (dec_bad)
  );

  // one-cycle latch clear pulses
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      clr_ch0_q <= 1'b0;
      clr_ch1_q <= 1'b0;
    end
    else
    begin
      clr_ch0_q <= code_wr_go && dec_ch0;
      clr_ch1_q <= code_wr_go && dec_ch1;
    end
  end

  assign serial_channel_zero_clear = clr_ch0_q;
  assign serial_channel_one_clear  = clr_ch1_q;

  // interrupt events
  always_comb
  begin
    irq_set                  = '0;
    irq_set[IRQ_NACK_POS]    = ack_sample && sda_s;
    irq_set[IRQ_ACK_POS]     = ack_sample && !sda_s;
    irq_set[IRQ_CLEARED_POS] = clr_ch0_q || clr_ch1_q;
    irq_set[IRQ_BADCODE_POS] = code_wr_go && dec_bad;
  end

  assign irq_clr = (wr_go && lane0 && address == IRQ_STAT_OFS) ? writedata[IRQ_BITS-1:0] : '0;

  // sticky status, write one to clear, set wins
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      irq_stat_q <= '0;
    else
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      irq_mask_q <= IRQ_MASK_RST;
    else if (wr_go && lane0 && address == IRQ_MASK_OFS)
      irq_mask_q <= writedata[IRQ_BITS-1:0];
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // read mux
  always_comb
  begin
    rd_mux = 32'h0;
    unique case (address)
      STATUS_OFS:
        rd_mux[ACK_VALUE_POS] = transmit_select_q ? bus_ack_q : ack_value_bit_q;
      CTRL_OFS:
      begin
        rd_mux[ACK_CHECK_POS] = ack_check_enable_q;
        rd_mux[TX_SELECT_POS] = transmit_select_q;
      end
      SWITCH_OFS:
        rd_mux = 32'h0;
      IRQ_STAT_OFS:
        rd_mux[IRQ_BITS-1:0] = irq_stat_q;
      IRQ_MASK_OFS:
        rd_mux[IRQ_BITS-1:0] = irq_mask_q;
      LINK_OFS:
      begin
        rd_mux[3:0] = bit_cnt_q;
        rd_mux[4]   = in_frame_q;
        rd_mux[5]   = ack_window_q;
        rd_mux[6]   = sda_oe_q;
      end
      default:
        rd_mux = 32'h0;
    endcase
  end

  // read data registered in the wait cycle, standing at the accepting edge
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      readdata_q <= 32'h0;
    else if (rd_first)
      readdata_q <= rd_mux;
  end

  assign readdata = readdata_q;

endmodule

// *** ack_latch_pkg.sv ***
package ack_latch_pkg;

  // register byte offsets
  localparam logic [4:0] STATUS_OFS   = 5'h00;
  localparam logic [4:0] CTRL_OFS     = 5'h04;
  localparam logic [4:0] SWITCH_OFS   = 5'h08;
  localparam logic [4:0] IRQ_STAT_OFS = 5'h0c;
  localparam logic [4:0] IRQ_MASK_OFS = 5'h10;
  localparam logic [4:0] LINK_OFS     = 5'h14;

  // field positions
  localparam int ACK_VALUE_POS   = 0;
  localparam int ACK_CHECK_POS   = 0;
  localparam int TX_SELECT_POS   = 1;
  localparam int IRQ_NACK_POS    = 0;
  localparam int IRQ_ACK_POS     = 1;
  localparam int IRQ_CLEARED_POS = 2;
  localparam int IRQ_BADCODE_POS = 3;
  localparam int IRQ_BITS        = 4;

  // reset values
  localparam logic       ACK_VALUE_RST  = 1'b0;
  localparam logic       ACK_CHECK_RST  = 1'b0;
  localparam logic       TX_SELECT_RST  = 1'b0;
  localparam logic [3:0] CLEAR_CODE_RST = 4'hf;
  localparam logic [3:0] IRQ_MASK_RST   = 4'h0;

  // clear codes
  localparam logic [3:0] CODE_CLEAR_CH0  = 4'h5;
  localparam logic [3:0] CODE_CLEAR_CH1  = 4'h6;
  localparam logic [3:0] CODE_CLEAR_BOTH = 4'h7;

  // rising scl edges counted before the acknowledge clock
  localparam logic [3:0] ACK_CLOCK_IDX = 4'h8;

endpackage

// *** pin_sync.sv ***
`timescale 1ns/10ps
module pin_sync
  import ack_latch_pkg::*;
(
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic srst,
  // pin in, synchronised out
  input  wire logic pin_in,
  output logic      pin_sync_q
);

  logic meta_q;

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      meta_q     <= 1'b1;
      pin_sync_q <= 1'b1;
    end
    else
    begin
      meta_q     <= pin_in;
      pin_sync_q <= meta_q;
    end
  end

endmodule

// *** clear_code_decode.sv ***
`timescale 1ns/10ps
module clear_code_decode
  import ack_latch_pkg::*;
(
  // written code
  input  wire logic [3:0] code,
  // decoded requests
  output logic            clear_ch0,
  output logic            clear_ch1,
  output logic            bad_code
);

  always_comb
  begin
    clear_ch0 = 1'b0;
    clear_ch1 = 1'b0;
    bad_code  = 1'b0;
    unique case (code)
      CODE_CLEAR_CH0:
        clear_ch0 = 1'b1;
      CODE_CLEAR_CH1:
        clear_ch1 = 1'b1;
      CODE_CLEAR_BOTH:
      begin
        clear_ch0 = 1'b1;
        clear_ch1 = 1'b1;
      end
      default:
        bad_code = 1'b1;
    endcase
  end

endmodule

// *** ack_latch_checker.sv ***
`timescale 1ns/10ps
module ack_latch_checker
  import ack_latch_pkg::*;
(
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        srst,
  // register bus
  input wire logic [4:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic [3:0]  byteenable,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  // pins and pulses
  input wire logic        sda_out,
  input wire logic        sda_oe,
  input wire logic        serial_channel_zero_clear,
  input wire logic        serial_channel_one_clear
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  // accepted switch write
  sequence sw_acc;
    write && !waitrequest && address == SWITCH_OFS && byteenable[0];
  endsequence
  sequence sw_code(logic [3:0] c);
    sw_acc ##0 writedata[3:0] == c;
  endsequence
  chk_clear_zero: assert property (sw_code(CODE_CLEAR_CH0) |=> serial_channel_zero_clear && !serial_channel_one_clear)
    else $error("zero code gave wrong pulses");
  chk_clear_one: assert property (sw_code(CODE_CLEAR_CH1) |=> !serial_channel_zero_clear && serial_channel_one_clear)
    else $error("one code gave wrong pulses");
  chk_clear_both: assert property (sw_code(CODE_CLEAR_BOTH) |=> serial_channel_zero_clear && serial_channel_one_clear)
    else $error("both code gave wrong pulses");
  chk_bad_code: assert property (sw_acc ##0 !(writedata[3:0] inside {[4'h5:4'h7]})
    |=> !serial_channel_zero_clear && !serial_channel_one_clear)
    else $error("refused code gave a pulse");
  chk_pulse_width: assert property ($rose(serial_channel_zero_clear) |=> !serial_channel_zero_clear)
    else $error("clear pulse too long");
  chk_switch_reads: assert property (read && !waitrequest && address == SWITCH_OFS |-> readdata == 32'h0)
    else $error("switch register read not zero");
  chk_wait_one: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus answer late");
  chk_oe_hold: assert property ($rose(sda_oe) |-> sda_oe[*4])
    else $error("acknowledge drive too short");
  chk_open_drain: assert property (sda_oe |-> !sda_out)
    else $error("sda driven high");
endmodule

bind ack_latch_ctrl ack_latch_checker ack_latch_checker_i (.sys_clk, .srst, .address, .read, .write, .writedata,
  .byteenable, .readdata, .waitrequest, .sda_out, .sda_oe, .serial_channel_zero_clear, .serial_channel_one_clear);

// *** bus_peer.sv ***
`timescale 1ns/10ps
module bus_peer (
  // clock
  input  wire logic sys_clk,
  // bus lines
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low,
  output logic      ack_seen
);
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
    ack_seen = 1'b1;
  end
  // quarter of an 80 ns link period
  task automatic step(input logic c, input logic lo);
    repeat (2) @(posedge sys_clk);
    scl <= c;
    sda_low <= lo;
  endtask
  // start, eight data bits, acknowledge clock, stop
  task automatic frame(input logic [7:0] data, input logic ack);
    logic b;
    step(1'b1, 1'b1);
    for (int i = 0; i < 9; i++)
    begin
      b = (i < 8) ? ~data[7-i] : ~ack;
      step(1'b0, sda_low);
      step(1'b0, b);
      step(1'b1, b);
      step(1'b1, b);
      if (i == 8)
        ack_seen = sda;
    end
    step(1'b0, sda_low);
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
  endtask
endmodule

// *** tb.sv ***
`timescale 1ns/10ps
module tb
  import ack_latch_pkg::*;
;
  logic        sys_clk;
  logic        srst;
  logic [4:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        scl_line;
  logic        sda_oe;
  logic        peer_low;
  logic        ack_seen;
  logic        zero_clr;
  logic        one_clr;
  logic        irq;
  int          err_count = 0;
  int          checks_done = 0;
  // pull-up on the data line
  wire         sda_line = ~(sda_oe | peer_low);

  ack_latch_ctrl ack_latch_ctrl_i (.sys_clk(sys_clk), .srst(srst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(4'h1), .readdata(readdata), .waitrequest(waitrequest),
    .scl_in(scl_line), .sda_in(sda_line), .sda_out(), .sda_oe(sda_oe), .serial_channel_zero_clear(zero_clr),
    .serial_channel_one_clear(one_clr), .irq(irq));
  bus_peer bus_peer_i (.sys_clk(sys_clk), .sda(sda_line), .scl(scl_line), .sda_low(peer_low), .ack_seen(ack_seen));

  task automatic finish_test;
    $display("errors %0d checks %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic bus(input logic is_wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge sys_clk);
    address <= a;
    writedata <= d;
    write <= is_wr;
    read <= ~is_wr;
    // waitrequest and readdata seen as they stood at each rising edge
    @(posedge sys_clk);
    while (waitrequest !== 1'b0)
      @(posedge sys_clk);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
    #1;
  endtask
  task automatic chk_rd(input string n, input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    cmp(n, e, q);
  endtask
  task automatic t_reset;
    chk_rd("status", STATUS_OFS, 32'h0);
    chk_rd("control", CTRL_OFS, 32'h0);
    chk_rd("switch", SWITCH_OFS, 32'h0);
    chk_rd("unmapped", 5'h1c, 32'h0);
  endtask
  task automatic t_clear;
    logic [3:0] c;
    for (int i = 0; i < 16; i++)
    begin
      c = i[3:0];
      wr(SWITCH_OFS, {24'h0, 4'h0, c});
      cmp("zero pulse", {31'h0, c == 4'h5 || c == 4'h7}, {31'h0, zero_clr});
      cmp("one pulse", {31'h0, c == 4'h6 || c == 4'h7}, {31'h0, one_clr});
      @(posedge sys_clk);
      #1;
      cmp("pulse end", 32'h0, {31'h0, zero_clr | one_clr});
      chk_rd("switch", SWITCH_OFS, 32'h0);
    end
  endtask
  task automatic t_rx;
    for (int v = 0; v < 2; v++)
    begin
      wr(STATUS_OFS, v);
      chk_rd("soft ack", STATUS_OFS, v);
      bus_peer_i.frame(8'h5a, 1'b1);
      cmp("ack sent", v, {31'h0, ack_seen});
    end
  endtask
  task automatic t_tx;
    wr(CTRL_OFS, 32'h3);
    wr(STATUS_OFS, 32'h0);
    bus_peer_i.frame(8'ha5, 1'b1);
    chk_rd("high ack", STATUS_OFS, 32'h1);
    chk_rd("irq status", IRQ_STAT_OFS, (32'h1 << IRQ_NACK_POS) | (32'h1 << IRQ_CLEARED_POS) | (32'h1 << IRQ_BADCODE_POS));
    cmp("irq masked", 32'h0, {31'h0, irq});
    wr(IRQ_MASK_OFS, 32'h1);
    cmp("irq on", 32'h1, {31'h0, irq});
    wr(IRQ_STAT_OFS, 32'hf);
    cmp("irq off", 32'h0, {31'h0, irq});
    chk_rd("irq cleared", IRQ_STAT_OFS, 32'h0);
    bus_peer_i.frame(8'ha5, 1'b0);
    chk_rd("low ack", STATUS_OFS, 32'h0);
    wr(STATUS_OFS, 32'h1);
    chk_rd("bus ack", STATUS_OFS, 32'h0);
    // the stored acknowledge is kept in transmit mode; turning the check off clears the bus acknowledge
    wr(STATUS_OFS, 32'h0);
    wr(STATUS_OFS, 32'h1);
    bus_peer_i.frame(8'h3c, 1'b1);
    wr(CTRL_OFS, 32'h2);
    chk_rd("check off", STATUS_OFS, 32'h0);
    wr(CTRL_OFS, 32'h0);
    chk_rd("stored ack", STATUS_OFS, 32'h1);
  endtask

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial
  begin
    #200000;
    err_count++;
    finish_test;
  end
  initial
  begin
    srst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 5'h0;
    writedata = 32'h0;
    repeat (4) @(posedge sys_clk);
    srst <= 1'b0;
    t_reset;
    t_clear;
    t_rx;
    t_tx;
    finish_test;
  end
endmodule
